// *** core/arb_pkg.sv ***
// Shared constants, types and register map of the acquisition RAM buffer manager.
`default_nettype none
package arb_pkg;

	// Channel count and sample layout: one sample is two bytes in one RAM word.
	localparam int NCH        = 16;
	localparam int CH_W       = 4;
	localparam int SMP_BYTES  = 2;
	localparam int SMP_W      = 8 * SMP_BYTES;

	// Memory sizes in bytes and the matching sample address widths.
	localparam int MEM_BYTES_STD = 32'h0040_0000;
	localparam int MEM_BYTES_EXT = 32'h0200_0000;
	localparam int MEM_AW_STD    = $clog2(MEM_BYTES_STD / SMP_BYTES);
	localparam int MEM_AW_EXT    = $clog2(MEM_BYTES_EXT / SMP_BYTES);

	// Avalon register map, byte addresses of 32-bit words.
	localparam int AV_AW = 6;
	localparam logic [AV_AW-1:0] OFS_CTRL    = 6'h00;
	localparam logic [AV_AW-1:0] OFS_CHAN_EN = 6'h04;
	localparam logic [AV_AW-1:0] OFS_TOTAL   = 6'h08;
	localparam logic [AV_AW-1:0] OFS_PRETRIG = 6'h0C;
	localparam logic [AV_AW-1:0] OFS_STATUS  = 6'h10;
	localparam logic [AV_AW-1:0] OFS_DEPTH   = 6'h14;
	localparam logic [AV_AW-1:0] OFS_RD_SEL  = 6'h18;
	localparam logic [AV_AW-1:0] OFS_RD_DATA = 6'h1C;
	localparam logic [AV_AW-1:0] OFS_LEVEL   = 6'h20;
	localparam logic [AV_AW-1:0] OFS_IRQ_ST  = 6'h24;
	localparam logic [AV_AW-1:0] OFS_IRQ_CLR = 6'h28;
	localparam logic [AV_AW-1:0] OFS_IRQ_EN  = 6'h2C;

	// Control word fields.
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP  = 1;
	localparam int CTRL_TRIG  = 2;
	localparam int CTRL_MODE  = 4;

	// Status word fields.
	localparam int STS_RUN   = 0;
	localparam int STS_TRIG  = 1;
	localparam int STS_DONE  = 2;
	localparam int STS_OVF   = 3;
	localparam int STS_CLAMP = 4;

	// Interrupt bit positions, shared by status, clear and enable.
	localparam int IRQ_W    = 4;
	localparam int IRQ_HALF = 0;
	localparam int IRQ_OVF  = 1;
	localparam int IRQ_DONE = 2;
	localparam int IRQ_TRIG = 3;

	// Reset values of the programmable words.
	localparam logic [31:0] TOTAL_RST = 32'h0000_0000;
	localparam logic [31:0] PRE_RST   = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_DONE = 3'b100
	} arb_state_t;

	typedef enum logic [1:0] {
		MODE_CIRC  = 2'h0,
		MODE_BLOCK = 2'h1,
		MODE_FIFO  = 2'h2
	} arb_mode_t;

	// One filtered sample with the channel it belongs to.
	typedef struct packed {
		logic [CH_W-1:0]  chan;
		logic [SMP_W-1:0] data;
	} arb_smp_t;

endpackage
`default_nettype wire

// *** core/arb_ram.sv ***
// Simple dual-port sample RAM with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module arb_ram #(
	parameter int AW = 21,
	parameter int W  = 16
) (
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	// Sample storage; the array carries no reset so it maps onto block RAM.
	logic [W-1:0] mem [2**AW];

	// Write port, one word per clock.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read port, one clock of latency.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule
`default_nettype wire

// *** core/arb_share.sv ***
// Splits the sample RAM evenly among the active channels.
`timescale 1ns/1ps
`default_nettype none
module arb_share #(
	parameter int AW  = 21,
	parameter int NCH = 16
) (
	input  wire logic [NCH-1:0]                       mask,
	output logic      [AW:0]                          depth,
	output logic      [$clog2(NCH):0]                 n_act,
	output logic      [NCH-1:0][$clog2(NCH):0]        rank
);
	// Rank of each channel is the count of active channels below it.
	always_comb begin
		logic [$clog2(NCH):0] acc;
		acc = '0;
		for (int c = 0; c < NCH; c++) begin
			rank[c] = acc;
			acc = acc + {{$clog2(NCH){1'b0}}, mask[c]};
		end
		n_act = acc;
		// The divide has a constant numerator, so it folds into a small table.
		depth = (acc == '0) ? '0 : (AW+1)'((2**AW) / int'(acc));
	end
endmodule
`default_nettype wire

// *** core/arb_core.sv ***
// Acquisition RAM buffer manager: per-channel buffers, capture modes and host access.
`timescale 1ns/1ps
`default_nettype none
module arb_core #(
	parameter int MEM_AW = arb_pkg::MEM_AW_STD
) (
	input  wire logic                     sys_clk,
	input  wire logic                     arst_n,
	input  wire logic [arb_pkg::AV_AW-1:0] avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [31:0]              avs_writedata,
	output logic      [31:0]              avs_readdata,
	output logic                          avs_waitrequest,
	input  wire logic                     smp_valid,
	input  wire arb_pkg::arb_smp_t        smp,
	input  wire logic                     trig_in,
	output logic                          irq
);
	localparam int DW  = MEM_AW + 1;
	localparam int NCH = arb_pkg::NCH;
	localparam int RW  = $clog2(NCH) + 1;

	typedef logic [DW-1:0] arb_cnt_t;

	// Run state, capture mode and the channel set latched at start.
	arb_pkg::arb_state_t state_reg;
	arb_pkg::arb_mode_t  mode_reg;
	logic [NCH-1:0]      en_reg;
	logic [NCH-1:0]      active_reg;
	logic [NCH-1:0]      fin_reg;
	logic [31:0]         total_reg;
	logic [31:0]         pre_reg;
	logic [arb_pkg::CH_W-1:0] sel_reg;
	logic                trig_reg;
	logic                ovf_reg;
	logic                clamp_reg;

	// Per-channel pointers, fill levels and counted writes.
	arb_cnt_t wr_reg   [NCH];
	arb_cnt_t rd_reg   [NCH];
	arb_cnt_t cnt_reg  [NCH];
	arb_cnt_t post_reg [NCH];

	// Interrupt registers.
	logic [arb_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [arb_pkg::IRQ_W-1:0] irq_en_reg;

	// Bus handshake registers.
	logic pend_reg;

	// Derived sizes and events.
	arb_cnt_t          depth;
	logic [RW-1:0]     n_act;
	logic [NCH-1:0][RW-1:0] rank;
	arb_cnt_t          eff_total;
	arb_cnt_t          eff_pre;
	arb_cnt_t          post_len;
	arb_cnt_t          lim;
	logic              circ;
	logic              fifo;
	logic              counted;
	logic [arb_pkg::CH_W-1:0] ch;
	logic              done_xfer;
	logic              wr_stb;
	logic              rd_stb;
	logic              start_stb;
	logic              stop_stb;
	logic              soft_trig;
	logic              pop;
	logic              pop_same;
	logic              w_ok;
	logic              ovf_evt;
	logic              wr_en;
	logic              drop;
	logic              half_evt;
	logic              fin_evt;
	logic              trig_evt;
	logic              all_fin;
	logic              done_evt;
	logic [MEM_AW-1:0] ram_waddr;
	logic [MEM_AW-1:0] ram_raddr;
	logic [arb_pkg::SMP_W-1:0] ram_q;
	logic [31:0]       rdval;
	logic [arb_pkg::IRQ_W-1:0] irq_set;
	logic [arb_pkg::IRQ_W-1:0] irq_clr;

	// Advances a pointer inside a region of the given depth, wrapping at its end.
	function automatic arb_cnt_t wrap_add(input arb_cnt_t ptr, input arb_cnt_t inc,
		input arb_cnt_t dep);
		arb_cnt_t s;
		s = ptr + inc;
		if (s >= dep) begin
			s = s - dep;
		end
		return s;
	endfunction

	// Region base of a channel: its rank times the equal share.
	function automatic logic [MEM_AW-1:0] base_of(input logic [RW-1:0] r, input arb_cnt_t dep);
		return MEM_AW'(r * dep);
	endfunction

	arb_share #(.AW(MEM_AW), .NCH(NCH)) u_share (
		.mask  (active_reg),
		.depth (depth),
		.n_act (n_act),
		.rank  (rank)
	);

	// Samples are stored as single two-byte words.
	arb_ram #(.AW(MEM_AW), .W(arb_pkg::SMP_W)) u_ram (
		.clk    (sys_clk),
		.arst_n (arst_n),
		.we     (wr_en),
		.waddr  (ram_waddr),
		.wdata  (smp.data),
		.raddr  (ram_raddr),
		.rdata  (ram_q)
	);

	// Bus strobes fire on the edge where the master sees waitrequest low.
	always_comb begin
		done_xfer = (avs_read || avs_write) && !avs_waitrequest;
		wr_stb    = done_xfer && avs_write;
		rd_stb    = done_xfer && avs_read && (avs_address == arb_pkg::OFS_RD_DATA);
		start_stb = wr_stb && (avs_address == arb_pkg::OFS_CTRL)
			&& avs_writedata[arb_pkg::CTRL_START];
		stop_stb  = wr_stb && (avs_address == arb_pkg::OFS_CTRL)
			&& avs_writedata[arb_pkg::CTRL_STOP];
		soft_trig = wr_stb && (avs_address == arb_pkg::OFS_CTRL)
			&& avs_writedata[arb_pkg::CTRL_TRIG];
	end

	// Capture bounds; the pre-trigger part never exceeds the total.
	always_comb begin
		eff_total = (total_reg > 32'(depth)) ? depth : DW'(total_reg);
		eff_pre   = (pre_reg > 32'(eff_total)) ? eff_total : DW'(pre_reg);
		post_len  = eff_total - eff_pre;
		circ      = (mode_reg == arb_pkg::MODE_CIRC);
		fifo      = (mode_reg == arb_pkg::MODE_FIFO);
		counted   = !circ || trig_reg;
		lim       = circ ? post_len : eff_total;
	end

	// Write-side decisions for the incoming sample.
	always_comb begin
		ch       = smp.chan;
		pop      = rd_stb && (cnt_reg[sel_reg] != '0);
		pop_same = pop && (sel_reg == ch);
		w_ok     = smp_valid && (state_reg == arb_pkg::ST_RUN) && active_reg[ch]
			&& !fin_reg[ch] && (depth != '0);
		ovf_evt  = w_ok && fifo && (cnt_reg[ch] == depth) && !pop_same;
		wr_en    = w_ok && !ovf_evt;
		// Pre-trigger history is capped at the pre-trigger amount by dropping the oldest.
		drop     = wr_en && circ && !trig_reg
			&& ((cnt_reg[ch] - DW'(pop_same)) >= eff_pre);
		half_evt = wr_en && fifo && !pop_same
			&& ((cnt_reg[ch] + 1'b1) == (depth >> 1));
		fin_evt  = wr_en && counted && !fifo && ((post_reg[ch] + 1'b1) == lim);
		trig_evt = (state_reg == arb_pkg::ST_RUN) && circ && !trig_reg
			&& (trig_in || soft_trig);
		all_fin  = ((fin_reg & active_reg) == active_reg);
		done_evt = (state_reg == arb_pkg::ST_RUN) && !fifo && all_fin && !start_stb;
		ram_waddr = base_of(rank[ch], depth) + MEM_AW'(wr_reg[ch]);
		ram_raddr = base_of(rank[sel_reg], depth) + MEM_AW'(rd_reg[sel_reg]);
	end

	// Per-channel pointer and level bookkeeping; writes and host pops meet here.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int c = 0; c < NCH; c++) begin
				wr_reg[c]   <= '0;
				rd_reg[c]   <= '0;
				cnt_reg[c]  <= '0;
				post_reg[c] <= '0;
			end
		end else if (start_stb) begin
			for (int c = 0; c < NCH; c++) begin
				wr_reg[c]   <= '0;
				rd_reg[c]   <= '0;
				cnt_reg[c]  <= '0;
				post_reg[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (wr_en && (ch == c)) begin
					wr_reg[c] <= wrap_add(wr_reg[c], DW'(1), depth);
					if (counted) begin
						post_reg[c] <= post_reg[c] + 1'b1;
					end
				end
				if ((pop && (sel_reg == c)) || (drop && (ch == c))) begin
					rd_reg[c] <= wrap_add(rd_reg[c],
						DW'(pop && (sel_reg == c)) + DW'(drop && (ch == c)), depth);
				end
				cnt_reg[c] <= cnt_reg[c] + DW'(wr_en && (ch == c))
					- DW'(pop && (sel_reg == c)) - DW'(drop && (ch == c));
			end
		end
	end

	// Outside FIFO mode, channels that have collected their capture count (total, or post-trigger part in circular mode) stop taking samples.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fin_reg <= '0;
		end else if (start_stb) begin
			fin_reg <= '0;
		end else if (trig_evt && (post_len == '0)) begin
			fin_reg <= active_reg;
		end else if (fin_evt) begin
			fin_reg[ch] <= 1'b1;
		end
	end

	// Measurement sequencing: start, trigger, completion, stop and overflow halt.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg  <= arb_pkg::ST_IDLE;
			active_reg <= '0;
			trig_reg   <= 1'b0;
			ovf_reg    <= 1'b0;
			clamp_reg  <= 1'b0;
		end else if (start_stb) begin
			// A start clears the overflow flag; apart from reset, nothing else does.
			state_reg  <= arb_pkg::ST_RUN;
			active_reg <= en_reg;
			trig_reg   <= 1'b0;
			ovf_reg    <= 1'b0;
			clamp_reg  <= (pre_reg > total_reg);
		end else begin
			unique case (state_reg)
				arb_pkg::ST_IDLE: begin
					state_reg <= arb_pkg::ST_IDLE;
				end
				arb_pkg::ST_RUN: begin
					if (stop_stb || ovf_evt || done_evt) begin
						state_reg <= arb_pkg::ST_DONE;
					end
				end
				arb_pkg::ST_DONE: begin
					state_reg <= arb_pkg::ST_DONE;
				end
			endcase
			if (trig_evt) begin
				trig_reg <= 1'b1;
			end
			if (ovf_evt) begin
				ovf_reg <= 1'b1;
			end
		end
	end

	// Software-written configuration; mode only changes while not running.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg   <= arb_pkg::MODE_CIRC;
			en_reg     <= '0;
			total_reg  <= arb_pkg::TOTAL_RST;
			pre_reg    <= arb_pkg::PRE_RST;
			sel_reg    <= '0;
			irq_en_reg <= '0;
		end else if (wr_stb) begin
			unique case (avs_address)
				arb_pkg::OFS_CTRL: begin
					if (state_reg != arb_pkg::ST_RUN) begin
						mode_reg <= arb_pkg::arb_mode_t'(avs_writedata[arb_pkg::CTRL_MODE +: 2]);
					end
				end
				arb_pkg::OFS_CHAN_EN: en_reg <= avs_writedata[NCH-1:0];
				arb_pkg::OFS_TOTAL: total_reg <= avs_writedata;
				arb_pkg::OFS_PRETRIG: pre_reg <= avs_writedata;
				arb_pkg::OFS_RD_SEL: sel_reg <= avs_writedata[arb_pkg::CH_W-1:0];
				arb_pkg::OFS_IRQ_EN: irq_en_reg <= avs_writedata[arb_pkg::IRQ_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// Sticky interrupt status; a new event in the clearing cycle is kept.
	always_comb begin
		irq_set = '0;
		irq_set[arb_pkg::IRQ_HALF] = half_evt;
		irq_set[arb_pkg::IRQ_OVF]  = ovf_evt;
		irq_set[arb_pkg::IRQ_DONE] = done_evt;
		irq_set[arb_pkg::IRQ_TRIG] = trig_evt;
		irq_clr = (wr_stb && (avs_address == arb_pkg::OFS_IRQ_CLR))
			? avs_writedata[arb_pkg::IRQ_W-1:0] : '0;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_reg <= '0;
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			irq          <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		rdval = '0;
		unique case (avs_address)
			arb_pkg::OFS_CTRL: rdval[arb_pkg::CTRL_MODE +: 2] = mode_reg;
			arb_pkg::OFS_CHAN_EN: rdval[NCH-1:0] = en_reg;
			arb_pkg::OFS_TOTAL: rdval = total_reg;
			arb_pkg::OFS_PRETRIG: rdval = pre_reg;
			arb_pkg::OFS_STATUS: begin
				rdval[arb_pkg::STS_RUN]   = (state_reg == arb_pkg::ST_RUN);
				rdval[arb_pkg::STS_TRIG]  = trig_reg;
				rdval[arb_pkg::STS_DONE]  = (state_reg == arb_pkg::ST_DONE);
				rdval[arb_pkg::STS_OVF]   = ovf_reg;
				rdval[arb_pkg::STS_CLAMP] = clamp_reg;
			end
			arb_pkg::OFS_DEPTH: rdval[DW-1:0] = depth;
			arb_pkg::OFS_RD_SEL: rdval[arb_pkg::CH_W-1:0] = sel_reg;
			arb_pkg::OFS_RD_DATA: begin
				// An empty buffer reads zero and is not popped.
				if (cnt_reg[sel_reg] != '0) begin
					rdval[arb_pkg::SMP_W-1:0] = ram_q;
				end
			end
			arb_pkg::OFS_LEVEL: rdval[DW-1:0] = cnt_reg[sel_reg];
			arb_pkg::OFS_IRQ_ST: rdval[arb_pkg::IRQ_W-1:0] = irq_stat_reg;
			arb_pkg::OFS_IRQ_EN: rdval[arb_pkg::IRQ_W-1:0] = irq_en_reg;
			default: rdval = '0;
		endcase
	end

	// Fixed two-cycle answer: one cycle lets the RAM address settle, the next drops wait.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg        <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
		end else if (done_xfer) begin
			avs_waitrequest <= 1'b1;
		end else if (pend_reg) begin
			pend_reg        <= 1'b0;
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? rdval : '0;
		end else if (avs_read || avs_write) begin
			pend_reg <= 1'b1;
		end
	end

	// Checks on the behaviour above.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	logic [arb_pkg::CH_W-1:0] last_ch_reg;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_ch_reg <= '0;
		end else begin
			last_ch_reg <= ch;
		end
	end

	sequence s_req_seen;
		(avs_read || avs_write) && avs_waitrequest && !pend_reg;
	endsequence
	sequence s_answer;
		pend_reg ##1 !avs_waitrequest;
	endsequence

	a_bus_answer: assert property (s_req_seen |=> s_answer)
		else $error("bus answer not two cycles after request");
	a_inactive_skip: assert property (smp_valid && !active_reg[ch] |-> !wr_en)
		else $error("inactive channel written");
	a_share_equal: assert property ((state_reg == arb_pkg::ST_RUN) && (n_act != '0)
		|-> (32'(depth) * 32'(n_act) <= 2**MEM_AW)
		&& ((32'(depth) + 1) * 32'(n_act) > 2**MEM_AW))
		else $error("shares are not equal");
	a_pre_clamp: assert property (eff_pre <= eff_total)
		else $error("pre-trigger exceeds total");
	a_pretrig_keep: assert property ((state_reg == arb_pkg::ST_RUN) && circ && !trig_reg
		|-> cnt_reg[ch] <= eff_pre)
		else $error("pre-trigger history grew past its limit");
	a_post_limit: assert property (wr_en && circ && trig_reg |-> post_reg[ch] < post_len)
		else $error("write beyond total count");
	a_half_irq: assert property (half_evt |=> irq_stat_reg[arb_pkg::IRQ_HALF])
		else $error("half-full event not latched");
	a_pop_nostall: assert property (pop_same && wr_en && !drop && !start_stb
		|=> cnt_reg[last_ch_reg] == $past(cnt_reg[ch]))
		else $error("host read and write in one cycle lost a sample");
	a_ovf_halt: assert property (ovf_evt && !start_stb
		|=> (state_reg == arb_pkg::ST_DONE) && ovf_reg && !wr_en)
		else $error("overflow did not halt");
	a_done_frozen: assert property ((state_reg == arb_pkg::ST_DONE) |-> !wr_en)
		else $error("write after halt");
	a_wr_wrap: assert property (wr_en |=> wr_reg[last_ch_reg] < depth)
		else $error("write pointer left its region");
	a_ovf_sticky: assert property (ovf_reg && !start_stb |=> ovf_reg)
		else $error("overflow flag dropped");
endmodule
`default_nettype wire

// *** bench/arb_host.sv ***
// Host computer model: an Avalon master that programs and drains the buffers.
`timescale 1ns/1ps
`default_nettype none
module arb_host (
	input  wire logic                      clk,
	output logic      [arb_pkg::AV_AW-1:0] address,
	output logic                           read,
	output logic                           write,
	output logic      [31:0]               writedata,
	input  wire logic [31:0]               readdata,
	input  wire logic                      waitrequest
);
	// The bus idles from time zero so nothing is requested during reset.
	initial begin
		address   = '0;
		read      = 1'b0;
		write     = 1'b0;
		writedata = '0;
	end

	// One transfer, held until waitrequest is sampled low; the host may run it while
	// samples keep arriving, which is how it drains buffers mid-run.
	task automatic xfer(input logic wr, input logic [arb_pkg::AV_AW-1:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		address   <= a;
		writedata <= d;
		read      <= ~wr;
		write     <= wr;
		// Values seen here are those sampled at the edge, before its updates land.
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** bench/tb_acquisition_ram_buffer_manager.sv ***
// Self-checking bench for the acquisition RAM buffer manager.
`timescale 1ns/1ps
`default_nettype none
module tb_acquisition_ram_buffer_manager;
	localparam int AW  = 6;       // A small RAM keeps the runs short.
	localparam int MEM = 1 << AW; // Samples in the whole RAM.
	logic                      sys_clk   = 1'b0; // 25 MHz clock.
	logic                      arst_n    = 1'b0; // Reset, active low.
	logic [arb_pkg::AV_AW-1:0] avs_address;      // Bus address from the host.
	logic                      avs_read;         // Bus read strobe.
	logic                      avs_write;        // Bus write strobe.
	logic [31:0]               avs_writedata;    // Bus write data.
	logic [31:0]               avs_readdata;     // Bus read data.
	logic                      avs_waitrequest;  // Bus answer, low when done.
	logic                      smp_valid = 1'b0; // Sample strobe.
	arb_pkg::arb_smp_t         smp       = '0;   // Sample and its channel.
	logic                      trig_in   = 1'b0; // Hardware trigger.
	logic                      irq;              // Interrupt line.
	int                        n_mismatch = 0;   // Failed comparisons.
	int                        n_compared = 0;   // All comparisons.
	int                        cyc        = 0;   // Cycle count for the timeout.

	always #20 sys_clk = ~sys_clk;

	arb_core #(.MEM_AW(AW)) u_dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.smp_valid(smp_valid), .smp(smp), .trig_in(trig_in), .irq(irq));

	arb_host u_host (
		.clk(sys_clk), .address(avs_address), .read(avs_read), .write(avs_write),
		.writedata(avs_writedata), .readdata(avs_readdata),
		.waitrequest(avs_waitrequest));

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Case equality, so an unknown never passes for a match.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_host.xfer(1'b1, a, d, q);
	endtask

	// Reads a register and compares only the bits under the mask.
	task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
		input string what);
		logic [31:0] q;
		u_host.xfer(1'b0, a, '0, q);
		chk(q & m, e, what);
	endtask

	// One sample, then a quiet edge so the strobe never changes twice in a step.
	task automatic send(input logic [3:0] c, input logic [15:0] d);
		@(posedge sys_clk);
		smp_valid <= 1'b1;
		smp       <= '{chan: c, data: d};
		@(posedge sys_clk);
		smp_valid <= 1'b0;
	endtask

	// Start in a mode; samples are usable from the first cycle after the start.
	task automatic start(input arb_pkg::arb_mode_t m);
		wr(arb_pkg::OFS_CTRL, {26'h000_0000, m, 4'h1});
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic t_reset();
		rd(arb_pkg::OFS_STATUS, '1, '0, "status after reset");
		rd(arb_pkg::OFS_IRQ_ST, '1, '0, "events after reset");
		rd(6'h30, '1, '0, "unmapped read");
		chk(32'(irq), '0, "irq after reset");
	endtask

	// Equal shares, inactive channel ignored, block capture held for reading.
	task automatic t_block();
		wr(arb_pkg::OFS_CHAN_EN, 32'h0000_0007);
		start(arb_pkg::MODE_BLOCK);
		rd(arb_pkg::OFS_DEPTH, '1, MEM / 3, "depth of three");
		wr(arb_pkg::OFS_CHAN_EN, 32'h0000_0003);
		wr(arb_pkg::OFS_TOTAL, 32'h0000_0004);
		start(arb_pkg::MODE_BLOCK);
		rd(arb_pkg::OFS_DEPTH, '1, MEM / 2, "depth of two");
		for (int i = 0; i < 6; i++) begin
			send(4'h0, 16'h0100 + 16'(i));
			send(4'h1, 16'h0200 + 16'(i));
			send(4'h5, 16'h0500 + 16'(i));
		end
		rd(arb_pkg::OFS_STATUS, 32'h0000_0004, 32'h0000_0004, "block done");
		wr(arb_pkg::OFS_RD_SEL, 32'h0000_0005);
		rd(arb_pkg::OFS_LEVEL, '1, '0, "inactive level");
		wr(arb_pkg::OFS_RD_SEL, 32'h0000_0000);
		rd(arb_pkg::OFS_LEVEL, '1, 32'h0000_0004, "block level");
		wr(arb_pkg::OFS_RD_SEL, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			rd(arb_pkg::OFS_RD_DATA, '1, 32'h0000_0200 + i, "block data");
		end
		rd(arb_pkg::OFS_RD_DATA, '1, '0, "empty pop");
	endtask

	// Pre-trigger wrap well past the region end, then the post-trigger count.
	task automatic t_circ();
		wr(arb_pkg::OFS_CHAN_EN, 32'h0000_0001);
		wr(arb_pkg::OFS_TOTAL, 32'h0000_0008);
		wr(arb_pkg::OFS_PRETRIG, 32'h0000_0003);
		wr(arb_pkg::OFS_IRQ_CLR, '1);
		start(arb_pkg::MODE_CIRC);
		for (int i = 0; i < 70; i++) send(4'h0, 16'h1000 + 16'(i));
		wr(arb_pkg::OFS_RD_SEL, 32'h0000_0000);
		rd(arb_pkg::OFS_LEVEL, '1, 32'h0000_0003, "history kept");
		rd(arb_pkg::OFS_STATUS, 32'h0000_0002, '0, "not triggered");
		@(posedge sys_clk);
		trig_in <= 1'b1;
		@(posedge sys_clk);
		trig_in <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rd(arb_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002, "triggered");
		for (int i = 0; i < 10; i++) send(4'h0, 16'h2000 + 16'(i));
		rd(arb_pkg::OFS_LEVEL, '1, 32'h0000_0008, "total reached");
		rd(arb_pkg::OFS_STATUS, 32'h0000_0004, 32'h0000_0004, "capture done");
		for (int i = 0; i < 8; i++) begin
			rd(arb_pkg::OFS_RD_DATA, '1, i < 3 ? 32'h0000_1043 + i : 32'h0000_2000 + i - 3,
				"capture data");
		end
		rd(arb_pkg::OFS_IRQ_ST, 32'h0000_000C, 32'h0000_000C, "trigger and done events");
		wr(arb_pkg::OFS_PRETRIG, 32'h0000_0009);
		start(arb_pkg::MODE_CIRC);
		rd(arb_pkg::OFS_STATUS, 32'h0000_0010, 32'h0000_0010, "pre-trigger clamp");
		// The clamped history leaves no post-trigger part, so a soft trigger ends the run.
		wr(arb_pkg::OFS_CTRL, 32'h0000_0004);
		rd(arb_pkg::OFS_STATUS, 32'h0000_0006, 32'h0000_0006, "soft trigger ends capture");
	endtask

	// Half event masked, enabled and cleared; drain while filling; overflow halt.
	task automatic t_fifo();
		wr(arb_pkg::OFS_IRQ_EN, '0);
		wr(arb_pkg::OFS_IRQ_CLR, '1);
		start(arb_pkg::MODE_FIFO);
		for (int i = 0; i < 32; i++) send(4'h0, 16'(i));
		rd(arb_pkg::OFS_IRQ_ST, 32'h0000_0001, 32'h0000_0001, "half event");
		chk(32'(irq), '0, "masked irq");
		wr(arb_pkg::OFS_IRQ_EN, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		chk(32'(irq), 32'h0000_0001, "enabled irq");
		wr(arb_pkg::OFS_IRQ_CLR, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		chk(32'(irq), '0, "cleared irq");
		fork
			for (int i = 32; i < 40; i++) send(4'h0, 16'(i));
			begin
				rd(arb_pkg::OFS_RD_DATA, '1, 32'h0000_0000, "drain first");
				rd(arb_pkg::OFS_RD_DATA, '1, 32'h0000_0001, "drain second");
			end
		join
		rd(arb_pkg::OFS_LEVEL, '1, 32'h0000_0026, "level while draining");
		for (int i = 40; i < 67; i++) send(4'h0, 16'(i));
		rd(arb_pkg::OFS_STATUS, 32'h0000_000C, 32'h0000_000C, "overflow halt");
		rd(arb_pkg::OFS_IRQ_ST, 32'h0000_0002, 32'h0000_0002, "overflow event");
		rd(arb_pkg::OFS_LEVEL, '1, MEM, "data kept");
		rd(arb_pkg::OFS_RD_DATA, '1, 32'h0000_0002, "oldest after halt");
		rd(arb_pkg::OFS_STATUS, 32'h0000_0008, 32'h0000_0008, "overflow held");
		start(arb_pkg::MODE_FIFO);
		rd(arb_pkg::OFS_STATUS, 32'h0000_0008, '0, "overflow cleared");
		// A host stop ends a running measurement without an overflow.
		wr(arb_pkg::OFS_CTRL, 32'h0000_0002);
		rd(arb_pkg::OFS_STATUS, 32'h0000_000D, 32'h0000_0004, "stopped by host");
	endtask

	// A hang counts as a mismatch and goes to the closing report.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			final_report();
		end
	end

	// Reset for five cycles, then the scenarios in turn.
	initial begin
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset();
		t_block();
		t_circ();
		t_fifo();
		final_report();
	end
endmodule
`default_nettype wire
